// [src/dgoc_pkg.sv]
`default_nettype none
package dgoc_pkg;
  // Serial frame: rw, 7-bit address, 2-bit channel mask, 16-bit word, MSB first
  localparam int unsigned FRAME_BITS = 26;
  localparam int unsigned HDR_BITS = 10;
  localparam logic [4:0] CNT_HDR_LAST = 5'h09;
  localparam logic [4:0] CNT_FRAME_LAST = 5'h19;
  // Pin vector positions and idle levels after reset
  localparam int unsigned PIN_SCLK = 0;
  localparam int unsigned PIN_CSN = 1;
  localparam int unsigned PIN_SDI = 2;
  localparam logic [2:0] PIN_IDLE = 3'h2;
  // Level words, written raw and read back corrected
  localparam logic [6:0] OFS_DRIVE_HIGH_LEVEL = 7'h01;
  localparam logic [6:0] OFS_TERMINATION_LEVEL = 7'h02;
  localparam logic [6:0] OFS_DRIVE_LOW_LEVEL = 7'h03;
  localparam logic [6:0] OFS_CLAMP_HIGH_LEVEL = 7'h04;
  localparam logic [6:0] OFS_LOAD_HIGH_CURRENT_LEVEL = 7'h08;
  // Mode and control
  localparam logic [6:0] OFS_LOAD_ENABLE = 7'h1B;
  localparam logic [6:0] OFS_DAC_CONTROL = 7'h1D;
  // Gain and offset words
  localparam logic [6:0] OFS_DRIVE_HIGH_GAIN = 7'h21;
  localparam logic [6:0] OFS_TERMINATION_GAIN = 7'h22;
  localparam logic [6:0] OFS_DRIVE_LOW_GAIN = 7'h23;
  localparam logic [6:0] OFS_CLAMP_HIGH_GAIN = 7'h24;
  localparam logic [6:0] OFS_LOAD_HIGH_GAIN = 7'h28;
  localparam logic [6:0] OFS_COMMUTATION_GAIN = 7'h42;
  localparam logic [6:0] OFS_DRIVE_HIGH_OFFSET = 7'h31;
  localparam logic [6:0] OFS_TERMINATION_OFFSET = 7'h32;
  localparam logic [6:0] OFS_DRIVE_LOW_OFFSET = 7'h33;
  localparam logic [6:0] OFS_CLAMP_HIGH_OFFSET = 7'h34;
  localparam logic [6:0] OFS_LOAD_HIGH_OFFSET = 7'h38;
  localparam logic [6:0] OFS_COMMUTATION_OFFSET = 7'h52;
  localparam logic [15:0] GAIN_RESET = 16'hFFFF;
  localparam logic [15:0] OFFSET_RESET = 16'h8000;
  localparam logic [18:0] OFFSET_MID = 19'h08000;
  localparam logic [15:0] WORD_MAX = 16'hFFFF;
  // Level converters per channel and calibration word slots per channel
  localparam int unsigned DAC_COUNT = 5;
  localparam logic [2:0] DAC_TERM = 3'h1;
  localparam int unsigned SLOT_COUNT = 12;
  localparam logic [3:0] SLOT_COMMUTATION = 4'h5;
  localparam logic [3:0] SLOT_OFFSET_BASE = 4'h6;

  typedef enum logic [1:0] {DGOC_IDLE, DGOC_FETCH_GAIN, DGOC_FETCH_OFFSET, DGOC_STORE} dgoc_state_t;

  // Returns {valid, slot}; slots 0..5 hold gains, 6..11 the matching offsets
  function automatic logic [4:0] cal_decode(input logic [6:0] addr);
    case (addr)
      OFS_DRIVE_HIGH_GAIN: cal_decode = 5'h10;
      OFS_TERMINATION_GAIN: cal_decode = 5'h11;
      OFS_DRIVE_LOW_GAIN: cal_decode = 5'h12;
      OFS_CLAMP_HIGH_GAIN: cal_decode = 5'h13;
      OFS_LOAD_HIGH_GAIN: cal_decode = 5'h14;
      OFS_COMMUTATION_GAIN: cal_decode = 5'h15;
      OFS_DRIVE_HIGH_OFFSET: cal_decode = 5'h16;
      OFS_TERMINATION_OFFSET: cal_decode = 5'h17;
      OFS_DRIVE_LOW_OFFSET: cal_decode = 5'h18;
      OFS_CLAMP_HIGH_OFFSET: cal_decode = 5'h19;
      OFS_LOAD_HIGH_OFFSET: cal_decode = 5'h1A;
      OFS_COMMUTATION_OFFSET: cal_decode = 5'h1B;
      default: cal_decode = 5'h00;
    endcase
  endfunction

  // Returns {valid, converter index}
  function automatic logic [3:0] level_decode(input logic [6:0] addr);
    case (addr)
      OFS_DRIVE_HIGH_LEVEL: level_decode = 4'h8;
      OFS_TERMINATION_LEVEL: level_decode = 4'h9;
      OFS_DRIVE_LOW_LEVEL: level_decode = 4'hA;
      OFS_CLAMP_HIGH_LEVEL: level_decode = 4'hB;
      OFS_LOAD_HIGH_CURRENT_LEVEL: level_decode = 4'hC;
      default: level_decode = 4'h0;
    endcase
  endfunction

  function automatic logic [3:0] gain_slot(input logic [2:0] dac, input logic load_en);
    gain_slot = (dac == DAC_TERM && load_en) ? SLOT_COMMUTATION : {1'b0, dac};
  endfunction
endpackage
`default_nettype wire

// [src/dgoc_cal_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface dgoc_cal_if;
  logic [1:0] we;
  logic [3:0] wslot;
  logic [15:0] wdata;
  logic re;
  logic [4:0] raddr;
  logic [15:0] rdata;
  modport ctl (output we, output wslot, output wdata, output re, output raddr, input rdata);
  modport mem (input we, input wslot, input wdata, input re, input raddr, output rdata);
endinterface
`default_nettype wire

// [src/dgoc_cal_mem.sv]
`timescale 1ns/1ps
`default_nettype none
module dgoc_cal_mem (
  // Clock
  input wire logic clk_i,
  // Calibration word access
  dgoc_cal_if.mem cal
);
  // Power-up defaults only; no reset reaches these words
  logic [15:0] bank_q [2][dgoc_pkg::SLOT_COUNT] = '{2{'{
    dgoc_pkg::GAIN_RESET, dgoc_pkg::GAIN_RESET, dgoc_pkg::GAIN_RESET,
    dgoc_pkg::GAIN_RESET, dgoc_pkg::GAIN_RESET, dgoc_pkg::GAIN_RESET,
    dgoc_pkg::OFFSET_RESET, dgoc_pkg::OFFSET_RESET, dgoc_pkg::OFFSET_RESET,
    dgoc_pkg::OFFSET_RESET, dgoc_pkg::OFFSET_RESET, dgoc_pkg::OFFSET_RESET}}};
  logic [15:0] rdata_q = 16'h0000;

  // One bank per channel so a dual-channel write lands in one cycle
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < 2; c++) begin
      if (cal.we[c]) begin
        bank_q[c][cal.wslot] <= cal.wdata;
      end
    end
    if (cal.re) begin
      rdata_q <= bank_q[cal.raddr[4]][cal.raddr[3:0]];
    end
  end

  assign cal.rdata = rdata_q;
endmodule
`default_nettype wire

// [src/dgoc_corr.sv]
`timescale 1ns/1ps
`default_nettype none
module dgoc_corr (
  // Correction control
  input wire logic en_i,
  // Operands
  input wire logic [15:0] x1_i,
  input wire logic [15:0] gain_i,
  input wire logic [15:0] offset_i,
  // Result
  output logic [15:0] y_o
);
  logic [16:0] gain_p1;
  logic [32:0] prod;
  logic [18:0] sum;

  always_comb begin
    gain_p1 = {1'b0, gain_i} + 17'h00001;
    prod = {17'h00000, x1_i} * {16'h0000, gain_p1};
    // Truncate the product, then add the offset less midscale
    sum = {2'h0, prod[32:16]} + {3'h0, offset_i} - dgoc_pkg::OFFSET_MID;
    if (!en_i) begin
      y_o = x1_i;
    end else if (sum[18]) begin
      y_o = 16'h0000;
    end else if (sum[17:16] != 2'h0) begin
      y_o = dgoc_pkg::WORD_MAX;
    end else begin
      y_o = sum[15:0];
    end
  end
endmodule
`default_nettype wire

// [src/dgoc_level_cal.sv]
// Notes on behaviour
// - Every level has its own gain and offset
// - Calibration words survive all resets, power defaults
// - Reset clears the global correction enable
// - Clearing the enable bypasses correction for all converters together
// - Result is x1 times (m+1)/2^16 plus c-2^15
// - Gain words power up at all ones
// - Offset words power up at midscale
// - One corrected holding word per converter drives output
// - Level readback returns the corrected holding word
// - Dual-channel write updates channel 0 then 1
// - Only raw level writes recompute holding words
// - Word pair chosen from modes at write time
// - Calibration applied only inside the level write sequence
// - Termination uses commutation pair when load enabled
// - Drive high always uses its own pair
// - Drive low always uses its own pair
// - Clamp high always uses its own pair
// - Load high current always uses its own pair
`timescale 1ns/1ps
`default_nettype none
module dgoc_level_cal (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Serial register port
  input wire logic spi_sclk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sdi_i,
  output logic spi_sdo_o,
  // Corrected holding words, channel 1 in the upper half
  output logic [159:0] dac_words_o
);
  dgoc_cal_if cal ();

  // Pin synchronisers
  logic [2:0] sync1_q, sync2_q, sync3_q, pin_q, pin_d;
  logic sclk_prev_q;
  logic sclk_rise, sclk_fall;

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pin_d[i] = (sync2_q[i] == sync3_q[i]) ? sync3_q[i] : pin_q[i];
    end
    sclk_rise = pin_q[dgoc_pkg::PIN_SCLK] & ~sclk_prev_q;
    sclk_fall = ~pin_q[dgoc_pkg::PIN_SCLK] & sclk_prev_q;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_q <= dgoc_pkg::PIN_IDLE;
      sync2_q <= dgoc_pkg::PIN_IDLE;
      sync3_q <= dgoc_pkg::PIN_IDLE;
      pin_q <= dgoc_pkg::PIN_IDLE;
      sclk_prev_q <= 1'b0;
    end else begin
      sync1_q <= {spi_sdi_i, spi_cs_n_i, spi_sclk_i};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pin_q <= pin_d;
      sclk_prev_q <= pin_q[dgoc_pkg::PIN_SCLK];
    end
  end

  // Serial frame, register writes and readback
  logic [4:0] bit_cnt_q, bit_cnt_d;
  logic [25:0] shin_q, shin_d;
  logic [15:0] shout_q, shout_d;
  logic sdo_q, sdo_d;
  logic fetch_q, fetch_d;
  logic cal_en_q, cal_en_d;
  logic [1:0] load_en_q, load_en_d;
  logic [15:0] hold_q [2][dgoc_pkg::DAC_COUNT];
  logic [4:0] cal_dec;
  logic [3:0] lvl_dec;
  logic [6:0] f_addr;
  logic [1:0] f_mask;
  logic rd_ch;
  logic start;
  logic spi_re;
  logic [4:0] spi_raddr;

  always_comb begin
    bit_cnt_d = bit_cnt_q;
    shin_d = shin_q;
    shout_d = shout_q;
    sdo_d = sdo_q;
    fetch_d = 1'b0;
    cal_en_d = cal_en_q;
    load_en_d = load_en_q;
    start = 1'b0;
    spi_re = 1'b0;
    spi_raddr = 5'h00;
    cal.we = 2'h0;
    cal.wslot = 4'h0;
    cal.wdata = 16'h0000;
    f_addr = 7'h00;
    f_mask = 2'h0;
    rd_ch = 1'b0;
    cal_dec = 5'h00;
    lvl_dec = 4'h0;
    if (pin_q[dgoc_pkg::PIN_CSN]) begin
      // Deselect drops any partial frame
      bit_cnt_d = 5'h00;
    end else if (sclk_rise) begin
      shin_d = {shin_q[24:0], pin_q[dgoc_pkg::PIN_SDI]};
      bit_cnt_d = bit_cnt_q + 5'h01;
      if (bit_cnt_q == dgoc_pkg::CNT_HDR_LAST && shin_d[9]) begin
        f_addr = shin_d[8:2];
        f_mask = shin_d[1:0];
        rd_ch = (f_mask == 2'h2);
        cal_dec = dgoc_pkg::cal_decode(f_addr);
        lvl_dec = dgoc_pkg::level_decode(f_addr);
        if (lvl_dec[3]) begin
          shout_d = hold_q[rd_ch][lvl_dec[2:0]];
        end else if (cal_dec[4]) begin
          spi_re = 1'b1;
          spi_raddr = {rd_ch, cal_dec[3:0]};
          fetch_d = 1'b1;
        end else if (f_addr == dgoc_pkg::OFS_LOAD_ENABLE) begin
          shout_d = {15'h0000, load_en_q[rd_ch]};
        end else if (f_addr == dgoc_pkg::OFS_DAC_CONTROL) begin
          shout_d = {15'h0000, cal_en_q};
        end else begin
          shout_d = 16'h0000;
        end
      end else if (bit_cnt_q == dgoc_pkg::CNT_FRAME_LAST && !shin_d[25]) begin
        f_addr = shin_d[24:18];
        f_mask = shin_d[17:16];
        cal_dec = dgoc_pkg::cal_decode(f_addr);
        lvl_dec = dgoc_pkg::level_decode(f_addr);
        if (lvl_dec[3]) begin
          start = (f_mask != 2'h0);
        end else if (cal_dec[4]) begin
          // Calibration writes never touch holding words
          cal.we = f_mask;
          cal.wslot = cal_dec[3:0];
          cal.wdata = shin_d[15:0];
        end else if (f_addr == dgoc_pkg::OFS_LOAD_ENABLE) begin
          for (int c = 0; c < 2; c++) begin
            if (f_mask[c]) begin
              load_en_d[c] = shin_d[0];
            end
          end
        end else if (f_addr == dgoc_pkg::OFS_DAC_CONTROL) begin
          cal_en_d = shin_d[0];
        end
      end
    end
    if (fetch_q) begin
      shout_d = cal.rdata;
    end
    if (!pin_q[dgoc_pkg::PIN_CSN] && sclk_fall) begin
      sdo_d = shout_q[15];
      shout_d = {shout_q[14:0], 1'b0};
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bit_cnt_q <= 5'h00;
      shin_q <= 26'h0000000;
      shout_q <= 16'h0000;
      sdo_q <= 1'b0;
      fetch_q <= 1'b0;
      cal_en_q <= 1'b0;
      load_en_q <= 2'h0;
    end else begin
      bit_cnt_q <= bit_cnt_d;
      shin_q <= shin_d;
      shout_q <= shout_d;
      sdo_q <= sdo_d;
      fetch_q <= fetch_d;
      cal_en_q <= cal_en_d;
      load_en_q <= load_en_d;
    end
  end

  // Correction sequence
  dgoc_pkg::dgoc_state_t st_q, st_d;
  logic ch_q, ch_d;
  logic pend_q, pend_d;
  logic [2:0] dac_q, dac_d;
  logic [15:0] x1_q, x1_d;
  logic [15:0] gain_q, gain_d;
  logic [1:0] le_q, le_d;
  logic [15:0] hold_d [2][dgoc_pkg::DAC_COUNT];
  logic [15:0] corr_y;
  logic [3:0] cur_gain_slot;
  logic fsm_re;
  logic [4:0] fsm_raddr;

  always_comb begin
    st_d = st_q;
    ch_d = ch_q;
    pend_d = pend_q;
    dac_d = dac_q;
    x1_d = x1_q;
    gain_d = gain_q;
    le_d = le_q;
    hold_d = hold_q;
    fsm_re = 1'b0;
    fsm_raddr = 5'h00;
    // Pair choice follows the load mode latched with the data
    cur_gain_slot = dgoc_pkg::gain_slot(dac_q, le_q[ch_q]);
    case (st_q)
      dgoc_pkg::DGOC_IDLE: begin
        if (start) begin
          st_d = dgoc_pkg::DGOC_FETCH_GAIN;
          ch_d = ~f_mask[0];
          pend_d = &f_mask;
          dac_d = lvl_dec[2:0];
          x1_d = shin_d[15:0];
          le_d = load_en_q;
        end
      end
      dgoc_pkg::DGOC_FETCH_GAIN: begin
        fsm_re = 1'b1;
        fsm_raddr = {ch_q, cur_gain_slot};
        st_d = dgoc_pkg::DGOC_FETCH_OFFSET;
      end
      dgoc_pkg::DGOC_FETCH_OFFSET: begin
        gain_d = cal.rdata;
        fsm_re = 1'b1;
        fsm_raddr = {ch_q, cur_gain_slot + dgoc_pkg::SLOT_OFFSET_BASE};
        st_d = dgoc_pkg::DGOC_STORE;
      end
      dgoc_pkg::DGOC_STORE: begin
        hold_d[ch_q][dac_q] = corr_y;
        if (pend_q) begin
          ch_d = 1'b1;
          pend_d = 1'b0;
          st_d = dgoc_pkg::DGOC_FETCH_GAIN;
        end else begin
          st_d = dgoc_pkg::DGOC_IDLE;
        end
      end
      default: begin
        st_d = dgoc_pkg::DGOC_IDLE;
      end
    endcase
    // The sequence owns the read port; readback collisions are a host timing fault
    cal.re = fsm_re | spi_re;
    cal.raddr = fsm_re ? fsm_raddr : spi_raddr;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q <= dgoc_pkg::DGOC_IDLE;
      ch_q <= 1'b0;
      pend_q <= 1'b0;
      dac_q <= 3'h0;
      x1_q <= 16'h0000;
      gain_q <= 16'h0000;
      le_q <= 2'h0;
      for (int c = 0; c < 2; c++) begin
        for (int d = 0; d < dgoc_pkg::DAC_COUNT; d++) begin
          hold_q[c][d] <= 16'h0000;
        end
      end
    end else begin
      st_q <= st_d;
      ch_q <= ch_d;
      pend_q <= pend_d;
      dac_q <= dac_d;
      x1_q <= x1_d;
      gain_q <= gain_d;
      le_q <= le_d;
      hold_q <= hold_d;
    end
  end

  dgoc_corr u_corr (
    .en_i(cal_en_q),
    .x1_i(x1_q),
    .gain_i(gain_q),
    .offset_i(cal.rdata),
    .y_o(corr_y)
  );

  dgoc_cal_mem u_mem (
    .clk_i(clk_i),
    .cal(cal)
  );

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      for (int d = 0; d < dgoc_pkg::DAC_COUNT; d++) begin
        dac_words_o[(c * 80) + (d * 16) +: 16] = hold_q[c][d];
      end
    end
  end

  assign spi_sdo_o = sdo_q;

  // Checks
  chk_enable_reset: assert property (
    @(posedge clk_i) $rose(resetn_i) |-> !cal_en_q)
    else $error("correction enable not cleared by reset");

  chk_store_only: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (dac_words_o != $past(dac_words_o)) |-> ($past(st_q) == dgoc_pkg::DGOC_STORE))
    else $error("holding word changed outside a level write");

  chk_bypass_raw: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (st_q == dgoc_pkg::DGOC_STORE && !cal_en_q) |-> (corr_y == x1_q))
    else $error("bypass did not pass raw word");

  chk_default_unity: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (st_q == dgoc_pkg::DGOC_STORE && cal_en_q && gain_q == 16'hFFFF
      && cal.rdata == 16'h8000) |-> (corr_y == x1_q))
    else $error("default words do not give identity");

  chk_dual_order: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (st_q == dgoc_pkg::DGOC_STORE && pend_q && !ch_q)
      |=> (st_q == dgoc_pkg::DGOC_FETCH_GAIN && ch_q) ##2 (st_q == dgoc_pkg::DGOC_STORE))
    else $error("second channel not updated after first");

  chk_walk_len: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (st_q == dgoc_pkg::DGOC_IDLE && start)
      |=> (st_q == dgoc_pkg::DGOC_FETCH_GAIN) ##1 (st_q == dgoc_pkg::DGOC_FETCH_OFFSET)
      ##1 (st_q == dgoc_pkg::DGOC_STORE))
    else $error("level write sequence malformed");

  chk_term_pair: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (st_q == dgoc_pkg::DGOC_FETCH_GAIN && dac_q == 3'h1)
      |-> (fsm_raddr[3:0] == (le_q[ch_q] ? 4'h5 : 4'h1))
      ##1 (fsm_raddr[3:0] == (le_q[ch_q] ? 4'hB : 4'h7)))
    else $error("termination pair selection wrong");

  chk_fixed_pair: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (st_q == dgoc_pkg::DGOC_FETCH_GAIN && dac_q != 3'h1)
      |-> (fsm_raddr == {ch_q, 1'b0, dac_q}) ##1 (fsm_raddr[3:0] == {1'b0, dac_q} + 4'h6))
    else $error("fixed pair selection wrong");

  chk_level_read: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (!pin_q[dgoc_pkg::PIN_CSN] && sclk_rise && bit_cnt_q == 5'h09 && shin_d[9]
      && lvl_dec[3] && !sclk_fall) |=> (shout_q == $past(hold_q[rd_ch][lvl_dec[2:0]])))
    else $error("level readback not the holding word");
endmodule
`default_nettype wire

// [verification/dgoc_spi_host.sv]
`timescale 1ns/1ps
`default_nettype none
module dgoc_spi_host (
  // Clock
  input wire logic clk_i,
  // Serial pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o,
  input wire logic sdo_i,
  // Read result, one cycle
  output logic rd_valid_o,
  output logic [15:0] rd_word_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
    rd_valid_o = 1'b0;
    rd_word_o = 16'h0000;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // Ten-clock phases leave margin over the four-clock pin filter
  task automatic xfer(input logic rw, input logic [6:0] addr, input logic [1:0] mask,
                      input logic [15:0] data);
    logic [25:0] frame;
    frame = {rw, addr, mask, data};
    cs_n_o = 1'b0;
    step(10);
    for (int i = 25; i >= 0; i--) begin
      sdi_o = frame[i];
      step(10);
      if (i < 16) rd_word_o[i] = sdo_i;
      sclk_o = 1'b1;
      step(10);
      sclk_o = 1'b0;
    end
    step(10);
    cs_n_o = 1'b1;
    // Released data line must not keep showing the last bit
    sdi_o = ~sdi_o;
    rd_valid_o = rw;
    step(1);
    rd_valid_o = 1'b0;
    step(12);
  endtask
endmodule
`default_nettype wire

// [verification/dgoc_level_cal_test.sv]
`timescale 1ns/1ps
`default_nettype none
module dgoc_level_cal_test;
  typedef struct {logic [15:0] exp; int idx;} dgoc_note_t;
  localparam logic [6:0] LVL [5] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h08};
  localparam logic [6:0] CAL [12] = '{7'h21, 7'h22, 7'h23, 7'h24, 7'h28, 7'h42,
                                      7'h31, 7'h32, 7'h33, 7'h34, 7'h38, 7'h52};
  logic clk_i, resetn_i, sclk, cs_n, sdi, sdo, rd_valid, look, cal_en;
  logic [1:0] load_en;
  logic [15:0] rd_word;
  logic [159:0] dac_words;
  logic [15:0] gain [2][6];
  logic [15:0] offs [2][6];
  logic [15:0] held [2][5];
  int look_idx, num_errors, n_checks;
  dgoc_note_t notes[$];

  dgoc_level_cal dut (.clk_i(clk_i), .resetn_i(resetn_i), .spi_sclk_i(sclk),
    .spi_cs_n_i(cs_n), .spi_sdi_i(sdi), .spi_sdo_o(sdo), .dac_words_o(dac_words));
  dgoc_spi_host host (.clk_i(clk_i), .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi),
    .sdo_i(sdo), .rd_valid_o(rd_valid), .rd_word_o(rd_word));

  function automatic logic [15:0] corr(input logic [15:0] x, input logic [15:0] m,
                                       input logic [15:0] c);
    longint s;
    s = ((longint'(x) * (longint'(m) + 1)) >>> 16) + longint'(c) - 32768;
    if (!cal_en) return x;
    return (s < 0) ? 16'h0000 : ((s > 65535) ? 16'hFFFF : s[15:0]);
  endfunction

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic rd(input logic [6:0] a, input int c, input logic [15:0] e);
    notes.push_back('{e, -1});
    host.xfer(1'b1, a, c ? 2'b10 : 2'b01, 16'h0000);
  endtask

  task automatic see(input int c, input int d);
    notes.push_back('{held[c][d], c * 5 + d});
    look_idx = c * 5 + d;
    look = 1'b1;
    host.step(1);
    look = 1'b0;
  endtask

  task automatic calw(input int sl, input int c, input logic [15:0] v);
    if (sl < 6) gain[c][sl] = v;
    else offs[c][sl - 6] = v;
    host.xfer(1'b0, CAL[sl], c ? 2'b10 : 2'b01, v);
  endtask

  task automatic lvl(input int d, input logic [1:0] m, input logic [15:0] x);
    int s;
    for (int c = 0; c < 2; c++) begin
      s = (d == 1 && load_en[c]) ? 5 : d;
      if (m[c]) held[c][d] = corr(x, gain[c][s], offs[c][s]);
    end
    host.xfer(1'b0, LVL[d], m, x);
  endtask

  task automatic rd_all_cal();
    for (int c = 0; c < 2; c++) begin
      for (int s = 0; s < 12; s++) begin
        rd(CAL[s], c, (s < 6) ? gain[c][s] : offs[c][s - 6]);
      end
    end
  endtask

  always @(posedge clk_i) begin
    if (rd_valid || look) begin
      dgoc_note_t n;
      logic [15:0] got;
      n = '{16'h0000, 0};
      if (notes.size() > 0) n = notes.pop_front();
      got = look ? dac_words[look_idx * 16 +: 16] : rd_word;
      n_checks++;
      if (got !== n.exp) begin
        num_errors++;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, n.exp);
      end
    end
  end

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    repeat (90000) @(posedge clk_i);
    num_errors++;
    end_sim();
  end

  initial begin
    resetn_i = 1'b0;
    look = 1'b0;
    look_idx = 0;
    num_errors = 0;
    n_checks = 0;
    cal_en = 1'b0;
    load_en = 2'b00;
    gain = '{default: 16'hFFFF};
    offs = '{default: 16'h8000};
    held = '{default: 16'h0000};
    void'($urandom(9));
    repeat (3) @(posedge clk_i);
    #1 resetn_i = 1'b1;
    host.step(6);
    rd_all_cal();
    rd(dgoc_pkg::OFS_DAC_CONTROL, 0, 16'h0000);
    rd(7'h7F, 0, 16'h0000);
    lvl(0, 2'b01, 16'($urandom));
    see(0, 0);
    // Host order: calibration and modes first, then fresh level data
    for (int c = 0; c < 2; c++) begin
      for (int s = 0; s < 12; s++) calw(s, c, 16'($urandom));
    end
    see(0, 0);
    host.xfer(1'b0, dgoc_pkg::OFS_DAC_CONTROL, 2'b01, 16'h0001);
    cal_en = 1'b1;
    see(0, 0);
    for (int c = 0; c < 2; c++) begin
      for (int d = 0; d < 5; d++) begin
        lvl(d, c ? 2'b10 : 2'b01, 16'($urandom));
        see(c, d);
        rd(LVL[d], c, held[c][d]);
      end
    end
    host.xfer(1'b0, dgoc_pkg::OFS_LOAD_ENABLE, 2'b11, 16'h0001);
    load_en = 2'b11;
    see(1, 1);
    lvl(1, 2'b11, 16'($urandom));
    see(0, 1);
    see(1, 1);
    host.xfer(1'b0, dgoc_pkg::OFS_LOAD_ENABLE, 2'b01, 16'h0000);
    load_en[0] = 1'b0;
    rd(dgoc_pkg::OFS_LOAD_ENABLE, 1, 16'h0001);
    lvl(1, 2'b11, 16'($urandom));
    see(0, 1);
    see(1, 1);
    calw(2, 0, 16'hFFFF);
    // Default gain and offset words must leave the raw word untouched
    calw(8, 0, 16'h8000);
    lvl(2, 2'b01, 16'($urandom));
    see(0, 2);
    calw(8, 0, 16'hFFFF);
    lvl(2, 2'b01, 16'hFFFF);
    see(0, 2);
    calw(8, 0, 16'h0000);
    lvl(2, 2'b01, 16'h1000);
    see(0, 2);
    host.xfer(1'b0, dgoc_pkg::OFS_DAC_CONTROL, 2'b01, 16'h0000);
    cal_en = 1'b0;
    lvl(3, 2'b10, 16'($urandom));
    see(1, 3);
    // Correction switched back on, so the reset below has an enable to clear
    host.xfer(1'b0, dgoc_pkg::OFS_DAC_CONTROL, 2'b01, 16'h0001);
    cal_en = 1'b1;
    rd(dgoc_pkg::OFS_DAC_CONTROL, 0, 16'h0001);
    // Second reset in mid-run: calibration words must survive it
    resetn_i = 1'b0;
    host.step(3);
    resetn_i = 1'b1;
    cal_en = 1'b0;
    load_en = 2'b00;
    held = '{default: 16'h0000};
    host.step(6);
    rd(dgoc_pkg::OFS_DAC_CONTROL, 0, 16'h0000);
    rd(dgoc_pkg::OFS_LOAD_ENABLE, 1, 16'h0000);
    rd_all_cal();
    lvl(4, 2'b01, 16'($urandom));
    see(0, 4);
    end_sim();
  end
endmodule
`default_nettype wire
